// ### core/ced_pkg.sv
// Constants and carriers for the cache error and tag diagnostic block
package ced_pkg;
	localparam logic [4:0] CED_SEL_LOCATION  = 5'h01;
	localparam logic [4:0] CED_SEL_TAG_IF    = 5'h02;
	localparam int         CED_WAY_HI        = 31;
	localparam int         CED_WAY_LO        = 30;
	localparam int         CED_IDX_HI        = 29;
	localparam int         CED_UNUSED_IDX_HI = 5;
	localparam int         CED_TAG_LO        = 12;
	localparam int         CED_VALID_BIT     = 7;
	localparam int         CED_DIRTY_BIT     = 6;
	localparam int         CED_LOCK_BIT      = 5;
	localparam int         CED_WAY_SELECT_REPLACEMENT_BITS_LO      = 10;
	localparam int         CED_WAY_SELECT_REPLACEMENT_BITS_HI      = 15;
	localparam int         CED_SIZE_LO       = 12;
	localparam int         CED_SIZE_HI       = 21;
	localparam logic [31:0] CED_TAG_MASK     = 32'hfffff0e0;
	localparam logic [31:0] CED_WS_MASK      = 32'h0000fc00;
	localparam logic [31:0] CED_PT0_MASK     = 32'hfffff080;
	localparam logic [31:0] CED_PT1_MASK     = 32'h003ff000;
	localparam logic [9:0]  CED_SIZE_MAX     = 10'h200;
	localparam logic [31:0] CED_RESET_VALUE  = 32'h00000000;

	typedef enum logic [1:0] {
		CED_ERR_DATA,
		CED_ERR_TAG,
		CED_ERR_DIRTY,
		CED_ERR_SPRAM
	} ced_err_type_e;

	typedef enum logic [1:0] {
		CED_LAY_TAG,
		CED_LAY_WS,
		CED_LAY_PT0,
		CED_LAY_PT1
	} ced_layout_e;

	// Error capture event from the detection logic
	typedef struct packed {
		logic          valid;
		logic          bus_parity;
		ced_err_type_e err_type;
		logic [1:0]    way;
		logic [29:0]   index;
	} ced_err_s;

	// Indexed tag operation toward the arrays
	typedef struct packed {
		logic       load;
		logic       store;
		logic       pseudo_tag1;
		logic [31:0] wdata;
	} ced_tagop_s;
endpackage

// ### core/ced_diag.sv
// Cache error location and instruction tag interface registers
`timescale 1ns/1ps
// Behaviour
// - Capture failing way in top two bits
// - Capture doubleword index in bits 29:0
// - Hardware writes way field on capture
// - Index is byte aligned, no shifting
// - Tag error: index bits 5:0 unused
// - Bus parity error: way field unused
// - Bus parity error: index 5:0 unused
// - Indexed load/store tag use tag interface
// - Way-select test redirects to way array
// - Tag mode bits 31:12 physical tag
// - Tag mode bit 7 valid
// - Dirty bit 6 only set with valid on tag load/store
// - Locked valid line never replaced
// - Reserved bits written zero, read zero
// - Way-select mode bits 15:10 replacement
// - Pseudo-tag 0 upper field base address
// - Pseudo-tag 0 bit 7 scratchpad enable
// - Pseudo-tag 1 bits 21:12 size
// - Size never exceeds 2MB maximum
// - Size writability fixed by implementation
// - Two-bit error type classifies error
// - Way-select test leaves tag arrays untouched
// - Scratchpad select routes ops to scratchpad unless way-select test is set
module ced_diag
	import ced_pkg::*;
#(
	parameter logic [9:0] SPR_SIZE_DEFAULT = 10'h001,
	parameter bit         SPR_SIZE_WRITABLE = 1'b0
) (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        cop_write,
	input  wire logic [4:0]  cop_sel,
	input  wire logic [31:0] cop_wdata,
	output logic      [31:0] cop_rdata,
	input  wire logic        way_select_test,
	input  wire logic        scratchpad_access_select,
	input  wire ced_err_s    err_event,
	output logic             status_update,
	output logic      [1:0]  error_array_type,
	input  wire ced_tagop_s  tag_op,
	output logic             tag_arr_wr,
	output logic             ws_arr_wr,
	output logic             spr_arr_wr,
	output logic      [31:0] arr_wdata,
	input  wire logic [31:0] tag_arr_rdata,
	input  wire logic [5:0]  ws_arr_rdata,
	input  wire logic [19:0] spr_base_rdata,
	input  wire logic        spr_enable_rdata,
	output logic             line_replace_block
);
	logic [31:0]   location_reg;
	logic [31:0]   location_next;
	logic [31:0]   tag_if_reg;
	logic [31:0]   tag_if_next;
	logic [1:0]    err_type_reg;
	logic          status_reg;
	logic [9:0]    size_reg;
	logic [9:0]    size_next;
	ced_layout_e   layout;
	logic [31:0]   lay_mask;
	logic [31:0]   load_value;
	logic [1:0]    cap_way;
	logic [29:0]   cap_index;
	wire           wr_loc = cop_write && cop_sel == CED_SEL_LOCATION;
	wire           wr_tag = cop_write && cop_sel == CED_SEL_TAG_IF;

	function automatic logic [9:0] clamp_size(input logic [9:0] s);
		return (s > CED_SIZE_MAX) ? CED_SIZE_MAX : s;
	endfunction

	assign layout = way_select_test ? CED_LAY_WS :
		!scratchpad_access_select ? CED_LAY_TAG :
		tag_op.pseudo_tag1 ? CED_LAY_PT1 : CED_LAY_PT0;

	assign lay_mask = (layout == CED_LAY_WS) ? CED_WS_MASK :
		(layout == CED_LAY_PT0) ? CED_PT0_MASK :
		(layout == CED_LAY_PT1) ? CED_PT1_MASK : CED_TAG_MASK;

	assign cap_way = err_event.bus_parity ? 2'b00 : err_event.way;
	assign cap_index = (err_event.bus_parity ||
		err_event.err_type == CED_ERR_TAG) ?
		{err_event.index[CED_IDX_HI:CED_UNUSED_IDX_HI + 1], 6'h00} :
		err_event.index;

	assign location_next = err_event.valid ? {cap_way, cap_index} :
		wr_loc ? cop_wdata : location_reg;

	always_comb begin
		load_value = CED_RESET_VALUE;
		case (layout)
			// Tag layout with dirty only if valid
			CED_LAY_TAG: begin
				load_value = tag_arr_rdata & CED_TAG_MASK;
				load_value[CED_DIRTY_BIT] = tag_arr_rdata[CED_DIRTY_BIT] &
					tag_arr_rdata[CED_VALID_BIT];
			end
			CED_LAY_WS:
				load_value[CED_WAY_SELECT_REPLACEMENT_BITS_HI:CED_WAY_SELECT_REPLACEMENT_BITS_LO] = ws_arr_rdata;
			CED_LAY_PT0: begin
				load_value[31:CED_TAG_LO] = spr_base_rdata;
				load_value[CED_VALID_BIT] = spr_enable_rdata;
			end
			CED_LAY_PT1:
				load_value[CED_SIZE_HI:CED_SIZE_LO] = size_reg;
			default:
				load_value = CED_RESET_VALUE;
		endcase
	end

	assign tag_if_next = tag_op.load ? load_value :
		wr_tag ? (cop_wdata & lay_mask) : tag_if_reg;

	assign size_next = (SPR_SIZE_WRITABLE && tag_op.store &&
		layout == CED_LAY_PT1) ?
		clamp_size(tag_if_reg[CED_SIZE_HI:CED_SIZE_LO]) : size_reg;

	assign tag_arr_wr = tag_op.store && layout == CED_LAY_TAG;
	assign ws_arr_wr  = tag_op.store && layout == CED_LAY_WS;
	assign spr_arr_wr = tag_op.store && scratchpad_access_select &&
		!way_select_test;
	always_comb begin
		arr_wdata = tag_if_reg & lay_mask;
		if (layout == CED_LAY_TAG)
			arr_wdata[CED_DIRTY_BIT] = tag_if_reg[CED_DIRTY_BIT] &
				tag_if_reg[CED_VALID_BIT];
	end

	assign line_replace_block = tag_arr_rdata[CED_LOCK_BIT] &
		tag_arr_rdata[CED_VALID_BIT];

	assign cop_rdata = (cop_sel == CED_SEL_LOCATION) ? location_reg :
		(cop_sel == CED_SEL_TAG_IF) ? tag_if_reg : CED_RESET_VALUE;
	assign status_update    = status_reg;
	assign error_array_type = err_type_reg;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			location_reg <= CED_RESET_VALUE;
			tag_if_reg   <= CED_RESET_VALUE;
			err_type_reg <= 2'h0;
			status_reg   <= 1'b0;
			size_reg     <= 10'h000;
		end else begin
			location_reg <= location_next;
			tag_if_reg   <= tag_if_next;
			if (err_event.valid)
				err_type_reg <= err_event.err_type;
			status_reg   <= err_event.valid;
			size_reg     <= size_reg == 10'h000 ?
				clamp_size(SPR_SIZE_DEFAULT) : size_next;
		end
	end

	chk_way_capture: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		err_event.valid && !err_event.bus_parity |=>
		location_reg[31:30] == $past(err_event.way))
		else $error("way not captured");
	chk_index_capture: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		err_event.valid && err_event.err_type == CED_ERR_DATA &&
		!err_event.bus_parity |=>
		location_reg[29:0] == $past(err_event.index))
		else $error("index not captured");
	chk_tag_low_zero: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		err_event.valid && err_event.err_type == CED_ERR_TAG |=>
		location_reg[5:0] == 6'h00)
		else $error("tag error low index");
	chk_bus_way_zero: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		err_event.valid && err_event.bus_parity |=>
		location_reg[31:30] == 2'b00)
		else $error("bus parity way");
	chk_bus_idx_zero: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		err_event.valid && err_event.bus_parity |=>
		location_reg[5:0] == 6'h00)
		else $error("bus parity index");
	chk_index_upper: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		err_event.valid |=>
		location_reg[29:6] == $past(err_event.index[29:6]))
		else $error("index shifted");
	chk_way_hw: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		err_event.valid && wr_loc && !err_event.bus_parity |=>
		location_reg[31:30] == $past(err_event.way))
		else $error("way not from hardware");
	chk_status_pulse: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		err_event.valid |=> status_update)
		else $error("status missing");
	chk_status_idle: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		!err_event.valid |=> !status_update)
		else $error("status spurious");
	chk_loc_hold: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		!err_event.valid && !wr_loc |=> $stable(location_reg))
		else $error("location moved");
	chk_loc_write: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		wr_loc && !err_event.valid |=> location_reg == $past(cop_wdata))
		else $error("location write lost");
	chk_type_capture: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		err_event.valid |=> error_array_type == $past(err_event.err_type))
		else $error("error type not captured");
	chk_type_hold: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		!err_event.valid |=> $stable(error_array_type))
		else $error("error type moved");
	chk_dirty_valid: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		tag_arr_wr |-> !arr_wdata[6] || arr_wdata[7])
		else $error("dirty without valid");
	chk_ws_no_tag: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		way_select_test |-> !tag_arr_wr)
		else $error("tag written in ws mode");
	chk_ws_store: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		way_select_test && tag_op.store |-> ws_arr_wr && !spr_arr_wr)
		else $error("ws store misrouted");
	chk_spr_route: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		scratchpad_access_select && !way_select_test && tag_op.store |->
		spr_arr_wr && !tag_arr_wr && !ws_arr_wr)
		else $error("scratchpad store misrouted");
	chk_layout_ws: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		way_select_test |-> layout == CED_LAY_WS)
		else $error("layout not way select");
	chk_reserved_zero: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		wr_tag && !tag_op.load |=>
		(tag_if_reg & ~$past(lay_mask)) == 32'h00000000)
		else $error("reserved bits set");
	chk_unmapped_zero: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		cop_sel != CED_SEL_LOCATION && cop_sel != CED_SEL_TAG_IF |->
		cop_rdata == 32'h00000000)
		else $error("unmapped read not zero");
	chk_tagif_hold: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		!tag_op.load && !wr_tag |=> $stable(tag_if_reg))
		else $error("tag interface moved");
	chk_tag_load: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		tag_op.load && !way_select_test && !scratchpad_access_select |=>
		tag_if_reg[31:12] == $past(tag_arr_rdata[31:12]))
		else $error("physical tag not loaded");
	chk_valid_load: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		tag_op.load && !way_select_test && !scratchpad_access_select |=>
		tag_if_reg[7] == $past(tag_arr_rdata[7]))
		else $error("valid not loaded");
	chk_dirty_load: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		tag_op.load && !way_select_test && !scratchpad_access_select |=>
		!tag_if_reg[6] || tag_if_reg[7])
		else $error("dirty loaded without valid");
	chk_ws_load: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		tag_op.load && way_select_test |=>
		tag_if_reg == {16'h0000, $past(ws_arr_rdata), 10'h000})
		else $error("way select bits not loaded");
	chk_pt0_base: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		tag_op.load && !way_select_test && scratchpad_access_select &&
		!tag_op.pseudo_tag1 |=>
		tag_if_reg[31:12] == $past(spr_base_rdata))
		else $error("base not loaded");
	chk_pt0_enable: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		tag_op.load && !way_select_test && scratchpad_access_select &&
		!tag_op.pseudo_tag1 |=>
		tag_if_reg[7] == $past(spr_enable_rdata))
		else $error("enable not loaded");
	chk_pt1_size: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		tag_op.load && !way_select_test && scratchpad_access_select &&
		tag_op.pseudo_tag1 |=>
		(tag_if_reg & ~CED_PT1_MASK) == 32'h00000000 &&
		tag_if_reg[21:12] != 10'h000)
		else $error("size field wrong");
	chk_size_max: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		##1 size_reg <= CED_SIZE_MAX)
		else $error("size over max");
	chk_size_fixed: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		size_reg != 10'h000 && !(SPR_SIZE_WRITABLE && tag_op.store) |=>
		$stable(size_reg))
		else $error("size changed");
	chk_lock_block: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		tag_arr_rdata[5] && tag_arr_rdata[7] |-> line_replace_block)
		else $error("locked line replaceable");
endmodule // ced_diag

// ### dv/ced_arrays.sv
// Behavioural instruction tag, way-select and scratchpad arrays
`timescale 1ns/1ps
module ced_arrays #(
	parameter logic [19:0] BASE_INIT = 20'h00400
) (
	input  wire logic        sys_clk,
	input  wire logic        tag_arr_wr,
	input  wire logic        ws_arr_wr,
	input  wire logic        spr_arr_wr,
	input  wire logic [31:0] arr_wdata,
	output logic      [31:0] tag_arr_rdata,
	output logic      [5:0]  ws_arr_rdata,
	output logic      [19:0] spr_base_rdata,
	output logic             spr_enable_rdata
);
	initial begin
		tag_arr_rdata = 32'h0;
		ws_arr_rdata = 6'h0;
		spr_base_rdata = BASE_INIT;
		spr_enable_rdata = 1'b1;
	end
	always @(posedge sys_clk) begin
		if (tag_arr_wr)
			tag_arr_rdata <= arr_wdata;
		if (ws_arr_wr)
			ws_arr_rdata <= arr_wdata[15:10];
		if (spr_arr_wr) begin
			spr_base_rdata <= arr_wdata[31:12];
			spr_enable_rdata <= arr_wdata[7];
		end
	end
endmodule // ced_arrays

// ### dv/cache_error_and_itag_diag_tb.sv
// Self-checking bench for the cache error and tag diagnostic block
`timescale 1ns/1ps
module cache_error_and_itag_diag_tb;
	import ced_pkg::*;
	localparam logic [19:0] BASE = 20'hab0cd;
	logic        sys_clk, reset_n, cop_write, way_select_test;
	logic        scratchpad_access_select, status_update, tag_arr_wr;
	logic        ws_arr_wr, spr_arr_wr, spr_enable_rdata, line_replace_block;
	logic [4:0]  cop_sel;
	logic [31:0] cop_wdata, cop_rdata, arr_wdata, tag_arr_rdata, r, msk;
	logic [1:0]  error_array_type;
	logic [5:0]  ws_arr_rdata;
	logic [19:0] spr_base_rdata;
	ced_err_s    err_event;
	ced_tagop_s  tag_op;
	int          miscompares, n_checks, cyc;

	ced_diag ced_diag_inst (.sys_clk(sys_clk), .reset_n(reset_n),
		.cop_write(cop_write), .cop_sel(cop_sel), .cop_wdata(cop_wdata),
		.cop_rdata(cop_rdata), .way_select_test(way_select_test),
		.scratchpad_access_select(scratchpad_access_select),
		.err_event(err_event), .status_update(status_update),
		.error_array_type(error_array_type), .tag_op(tag_op),
		.tag_arr_wr(tag_arr_wr), .ws_arr_wr(ws_arr_wr),
		.spr_arr_wr(spr_arr_wr), .arr_wdata(arr_wdata),
		.tag_arr_rdata(tag_arr_rdata), .ws_arr_rdata(ws_arr_rdata),
		.spr_base_rdata(spr_base_rdata),
		.spr_enable_rdata(spr_enable_rdata),
		.line_replace_block(line_replace_block));
	ced_arrays #(.BASE_INIT(BASE)) ced_arrays_inst (.sys_clk(sys_clk),
		.tag_arr_wr(tag_arr_wr), .ws_arr_wr(ws_arr_wr),
		.spr_arr_wr(spr_arr_wr), .arr_wdata(arr_wdata),
		.tag_arr_rdata(tag_arr_rdata), .ws_arr_rdata(ws_arr_rdata),
		.spr_base_rdata(spr_base_rdata),
		.spr_enable_rdata(spr_enable_rdata));

	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	task automatic end_of_test();
		if (miscompares == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rd(input logic [4:0] s, input logic [31:0] e);
		cop_sel = s;
		#1;
		chk(cop_rdata, e);
	endtask
	task automatic wr(input logic [4:0] s, input logic [31:0] d);
		cop_sel = s;
		cop_wdata = d;
		cop_write = 1'b1;
		tick();
		cop_write = 1'b0;
	endtask
	task automatic err(input int t, input logic bp, input logic [31:0] v);
		logic [31:0] e;
		e = {bp ? 2'h0 : v[31:30], v[29:0]};
		if (bp || t == 1)
			e[5:0] = 6'h0;
		err_event = '{1'b1, bp, ced_err_type_e'(t), v[31:30], v[29:0]};
		tick();
		err_event.valid = 1'b0;
		cop_write = 1'b0;
		chk(status_update, 32'h1);
		chk(error_array_type, t[1:0]);
		rd(CED_SEL_LOCATION, e);
		tick();
		chk(status_update, 32'h0);
	endtask
	task automatic op(input logic pt1);
		tag_op = '{1'b1, 1'b0, pt1, 32'h0};
		tick();
		tag_op.load = 1'b0;
	endtask
	task automatic store(input logic [31:0] e, input logic [2:0] s);
		tag_op.store = 1'b1;
		#1;
		chk({tag_arr_wr, ws_arr_wr, spr_arr_wr}, s);
		chk(arr_wdata, e);
		tick();
		tag_op.store = 1'b0;
	endtask

	initial begin
		{reset_n, cop_write, way_select_test} = '0;
		scratchpad_access_select = 1'b0;
		cop_sel = '0;
		cop_wdata = '0;
		err_event = '0;
		tag_op = '0;
		r = $urandom(42706);
		repeat (10) @(posedge sys_clk);
		#1 reset_n = 1'b1;
		tick();
		tick();
		rd(CED_SEL_LOCATION, 32'h0);
		rd(CED_SEL_TAG_IF, 32'h0);
		rd(5'h00, 32'h0);
		rd(5'h1f, 32'h0);
		for (int k = 0; k < 8; k++)
			err(k % 4, k[2], $urandom);
		cop_sel = CED_SEL_LOCATION;
		cop_wdata = 32'hffffffff;
		cop_write = 1'b1;
		err(0, 1'b0, 32'h80000040);
		r = $urandom;
		wr(CED_SEL_LOCATION, r);
		rd(CED_SEL_LOCATION, r);
		for (int m = 0; m < 2; m++) begin
			way_select_test = m[0];
			msk = m ? CED_WS_MASK : CED_TAG_MASK;
			for (int k = 0; k < 5; k++) begin
				r = k ? $urandom : 32'hffffffff;
				r[7] = r[7] | r[6];
				wr(CED_SEL_TAG_IF, r);
				rd(CED_SEL_TAG_IF, r & msk);
				store(r & msk, m ? 3'b010 : 3'b100);
				if (m == 0)
					chk(line_replace_block, r[7] & r[5]);
				wr(CED_SEL_TAG_IF, 32'h0);
				op(1'b0);
				rd(CED_SEL_TAG_IF, r & msk);
			end
		end
		way_select_test = 1'b0;
		scratchpad_access_select = 1'b1;
		op(1'b0);
		rd(CED_SEL_TAG_IF, {BASE, 12'h080});
		op(1'b1);
		rd(CED_SEL_TAG_IF, 32'h00001000);
		store(32'h00001000, 3'b001);
		end_of_test();
	end
endmodule // cache_error_and_itag_diag_tb
